// file: hw/lcp_defs.vh
// Constants for the LCD controller host port block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef LCP_DEFS_VH
`define LCP_DEFS_VH
// Register offsets on the host address bus
`define LCP_REG_POWER_SAVE     16'h0008
`define LCP_REG_DISPLAY_ENABLE 16'h0009
// Indirect command window base and command codes
`define LCP_IND_BASE           16'h8000
`define LCP_CMD_POWER_SAVE     8'h53
`define LCP_CMD_DISP_OFF       8'h58
`define LCP_CMD_DISP_ON        8'h59
// Field positions
`define LCP_PS_EN_BIT          0
`define LCP_DISP_EN_BIT        0
// Reset values
`define LCP_POWER_SAVE_RST     8'h00
`define LCP_DISPLAY_EN_RST     8'h00
// Bus variant encodings
`define LCP_BUS_GENERIC        2'h0
`define LCP_BUS_GENERIC_WAIT   2'h1
`define LCP_BUS_ASTROBE        2'h2
`define LCP_BUS_ASTROBE_WAIT   2'h3
// Timing: system clock period in ns, read access hold-off in periods
`define LCP_SYS_CLK_PERIOD_NS  10
`define LCP_READ_LAT_TS        4
`define LCP_WAIT_MAX_TS        4
`define LCP_FRAME_LIMIT        2
`endif

// file: hw/lcp_host_port.v
// Host-side parallel port of a graphics LCD controller: strobe decode,
// write capture, read return, wait handshake and panel disable control.
// Assumes host pins synchronous to sys_clk; frame_tick pulses once a frame.
`timescale 1ns/10ps
`include "lcp_defs.vh"

module lcp_host_port #(
  parameter BUS_MODE = `LCP_BUS_GENERIC_WAIT, // Bus variant
  parameter FALL_CAP = 0                      // 1: clocked indirect variant
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // Host bus
  input  wire        cs_n,
  input  wire        rd_n,
  input  wire        wr_n,
  input  wire        addr_strobe_n,
  input  wire [15:0] host_addr_bus,
  input  wire [7:0]  host_data_bus_in,
  output reg  [7:0]  host_data_bus_out,
  output wire        host_data_bus_oe,
  // Wait handshake, active low, three-state
  output wire        wait_out_n,
  output wire        wait_oe,
  // Mode and panel
  input  wire        direct_mode,
  input  wire        frame_tick,
  output reg         panel_disable_out
);

  // Transfer states. Only reads pass through busy and done; writes are
  // taken on the strobe edge alone and never hold the host off.
  localparam ST_IDLE = 2'h0; // No transfer
  localparam ST_BUSY = 2'h1; // Access in progress, wait asserted
  localparam ST_DONE = 2'h2; // Data ready, wait released

  reg  [1:0] rst_sync;          // Reset release synchroniser
  wire       rst_n_i;           // Synchronised reset
  reg  [7:0] power_save_control;     // Offset 08h
  reg  [7:0] display_enable_control; // Offset 09h
  reg  [1:0] state;             // Transfer state
  reg  [1:0] next_state;
  reg  [2:0] lat_cnt;           // Read access count
  reg        rd_q;              // Last transfer strobe level
  reg        wr_q;              // Last write strobe level
  reg  [1:0] frame_cnt;         // Frames since power save set
  reg        disp_off_cmd;      // Indirect display off issued

  wire has_wait = (BUS_MODE == `LCP_BUS_GENERIC_WAIT) || (BUS_MODE == `LCP_BUS_ASTROBE_WAIT);
  // Variant decode is static; each instance serves exactly one bus flavour
  wire astrobe  = (BUS_MODE == `LCP_BUS_ASTROBE) || (BUS_MODE == `LCP_BUS_ASTROBE_WAIT);
  // Address-strobe buses use one strobe for both directions
  wire xfer_n   = astrobe ? rd_n : (rd_n & wr_n);
  wire is_write = astrobe ? ~wr_n : ~wr_n;
  wire active   = ~cs_n & ~xfer_n & (~astrobe | ~addr_strobe_n);
  wire ps_on    = power_save_control[`LCP_PS_EN_BIT];
  wire disp_on  = display_enable_control[`LCP_DISP_EN_BIT];

  // Reset release through two flops. Assertion stays asynchronous so the
  // port goes quiet at once; release is clocked so no flop sees a runt
  // recovery edge. The host must wait two clocks after release.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n_i = rst_sync[1];

  // Transfer state decode; host must hold strobe through busy
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (active && !is_write)
          next_state = ST_BUSY;
      end
      ST_BUSY: begin
        // A host that drops the strobe early aborts the read cleanly;
        // otherwise four busy clocks keep the hold-off inside its limit
        if (!active)
          next_state = ST_IDLE;
        else if ({29'h0, lat_cnt} == (`LCP_WAIT_MAX_TS - 1))
          next_state = ST_DONE;
      end
      ST_DONE: begin
        if (!active)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State, latency count and strobe history
  // The count restarts whenever the port leaves busy, so an aborted read
  // cannot shorten the hold-off of the next one. Strobe history resets
  // to the idle level so no false edge follows reset.
  always @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= ST_IDLE;
      lat_cnt <= 3'h0;
      rd_q    <= 1'b1;
      wr_q    <= 1'b1;
    end else begin
      state <= next_state;
      rd_q  <= xfer_n;
      wr_q  <= wr_n;
      if (state == ST_BUSY)
        lat_cnt <= lat_cnt + 3'h1;
      else
        lat_cnt <= 3'h0;
    end
  end

  // Write capture edge: rising strobe, or falling for clocked indirect
  // Edge detection uses the strobe history flops, so a strobe that rises
  // while chip select is already high is ignored.
  wire wr_rise = astrobe ? (xfer_n & ~rd_q & ~wr_n) : (wr_n & ~wr_q);
  wire wr_fall = ~xfer_n & rd_q & ~wr_n;
  wire wr_take = ~cs_n & (FALL_CAP ? wr_fall : wr_rise);

  // Register writes and indirect command decode
  // Unmapped offsets are dropped silently; only the enable bits act on
  // the panel output.
  always @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_save_control     <= `LCP_POWER_SAVE_RST;
      display_enable_control <= `LCP_DISPLAY_EN_RST;
      disp_off_cmd           <= 1'b0;
    end else if (wr_take) begin
      if (host_addr_bus == `LCP_REG_POWER_SAVE)
        power_save_control <= host_data_bus_in;
      if (host_addr_bus == `LCP_REG_DISPLAY_ENABLE) begin
        display_enable_control <= host_data_bus_in;
        disp_off_cmd <= 1'b0;
      end
      if (host_addr_bus == `LCP_IND_BASE) begin
        // Indirect commands alter the same control bits
        if (host_data_bus_in == `LCP_CMD_DISP_OFF) begin
          display_enable_control[`LCP_DISP_EN_BIT] <= 1'b0;
          disp_off_cmd <= 1'b1;
        end else if (host_data_bus_in == `LCP_CMD_DISP_ON) begin
          display_enable_control[`LCP_DISP_EN_BIT] <= 1'b1;
          disp_off_cmd <= 1'b0;
        end else if (host_data_bus_in == `LCP_CMD_POWER_SAVE)
          power_save_control[`LCP_PS_EN_BIT] <= 1'b1;
      end
    end
  end

  // Read data from flops; ready by the fourth period at most
  // The word follows the address every clock, not the strobe, which costs a
  // little toggling but gives the host data one clock after its address.
  always @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i)
      host_data_bus_out <= 8'h00;
    else if (host_addr_bus == `LCP_REG_POWER_SAVE)
      host_data_bus_out <= power_save_control;
    else if (host_addr_bus == `LCP_REG_DISPLAY_ENABLE)
      host_data_bus_out <= display_enable_control;
    else
      host_data_bus_out <= 8'h00; // Unmapped reads return zero
  end
  assign host_data_bus_oe = ~cs_n & ~rd_n & (astrobe ? wr_n : 1'b1);

  // Wait: driven low while busy, then driven high once data stands so the
  // host sees a rising edge to mark completion; it floats again when the
  // strobe goes away and the state falls back to idle
  // The one exception is the address-strobe handshake in direct mode with
  // power save, where the line is left floating after busy
  // Limitation: a host that polls the line must keep a pull-up on it.
  assign wait_out_n = (state != ST_BUSY);
  assign wait_oe    = has_wait & ((state == ST_BUSY) |
                      ((state == ST_DONE) & ~(astrobe & direct_mode & ps_on)));

  // Frame count after power save set; the panel limit is reached at one frame
  // Saturates so a long power save never wraps back below the limit
  // and briefly lets the panel output rise again.
  always @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i)
      frame_cnt <= 2'h0;
    else if (!ps_on)
      frame_cnt <= 2'h0;
    else if (frame_tick && frame_cnt != 2'h3)
      frame_cnt <= frame_cnt + 2'h1;
  end

  // Panel disable output, high while display runs
  always @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i)
      panel_disable_out <= 1'b0;
    else if (ps_on && !direct_mode && {30'h0, frame_cnt} >= (`LCP_FRAME_LIMIT - 1))
      panel_disable_out <= 1'b0;
    else if (!disp_on || disp_off_cmd)
      panel_disable_out <= 1'b0;
    else
      // Indirect power save waits for a frame so the panel drops cleanly at
      // a frame boundary; direct power save drops it at once
      panel_disable_out <= ~(ps_on & direct_mode);
  end

endmodule

// file: dv/lcp_host_port_asserts.sv
// Pin-level checks of the host port, wait handshake strobe bus.
// Assumes the default bus variant; bound to every port instance.
`timescale 1ns/10ps
`include "lcp_defs.vh"
module lcp_host_port_asserts (
  // Clock and reset
  input wire        sys_clk,
  input wire        reset_n,
  // Host bus
  input wire        cs_n,
  input wire        rd_n,
  input wire        wr_n,
  input wire [15:0] host_addr_bus,
  input wire [7:0]  host_data_bus_in,
  input wire [7:0]  host_data_bus_out,
  input wire        host_data_bus_oe,
  input wire        wait_out_n,
  input wire        wait_oe,
  // Mode and panel
  input wire        direct_mode,
  input wire        panel_disable_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wait_start_a: assert property (
    $fell(rd_n) && !cs_n |-> ##[1:2] (wait_oe && !wait_out_n)) else $error("wait not driven");
  wait_len_a: assert property (
    $fell(wait_out_n) && wait_oe |-> ##[1:4] wait_out_n) else $error("wait held too long");
  wait_free_a: assert property (
    $rose(rd_n) |-> ##[0:1] !wait_oe) else $error("wait not released");
  data_ready_a: assert property (
    $rose(wait_out_n) && wait_oe |-> $stable(host_data_bus_out) && host_data_bus_oe) else $error("data late");
  data_drive_a: assert property (
    host_data_bus_oe == (!cs_n && !rd_n)) else $error("data bus enable wrong");
  data_settle_a: assert property (
    (!cs_n && !rd_n && $stable(host_addr_bus)) [*5] |-> $stable(host_data_bus_out)) else $error("data moving");
  // Direct writes of the display enable bit, and the indirect display off command
  disp_on_a: assert property (
    $rose(wr_n) && !cs_n && direct_mode && host_addr_bus == `LCP_REG_DISPLAY_ENABLE && host_data_bus_in[0]
    |-> ##[1:3] panel_disable_out) else $error("panel not raised");
  disp_off_a: assert property (
    $rose(wr_n) && !cs_n && direct_mode && host_addr_bus == `LCP_REG_DISPLAY_ENABLE && !host_data_bus_in[0]
    |-> ##[1:3] !panel_disable_out) else $error("panel not dropped");
  cmd_off_a: assert property (
    $rose(wr_n) && !cs_n && !direct_mode && host_addr_bus == `LCP_IND_BASE && host_data_bus_in == `LCP_CMD_DISP_OFF
    |-> ##[1:3] !panel_disable_out) else $error("off command ignored");
endmodule
bind lcp_host_port lcp_host_port_asserts chk (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .host_addr_bus(host_addr_bus), .host_data_bus_in(host_data_bus_in), .wait_oe(wait_oe),
  .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe), .wait_out_n(wait_out_n),
  .direct_mode(direct_mode), .panel_disable_out(panel_disable_out));

// file: dv/lcp_host_model.sv
// Host processor model driving the strobe bus at falling clock edges.
// Assumes the wait handshake variant; released lines show inverted data.
// Every pin changes only off sys_clk, the host's own clock
`timescale 1ns/10ps
module lcp_host_model (
  // Clock
  input wire         sys_clk,
  // Bus toward the port
  output reg         cs_n,
  output reg         rd_n,
  output reg         wr_n,
  output reg         addr_strobe_n,
  output reg  [15:0] host_addr_bus,
  output reg  [7:0]  host_data_bus_in,
  input  wire [7:0]  host_data_bus_out,
  input  wire        wait_out_n,
  input  wire        wait_oe
);
  integer i;        // Handshake bound
  integer late = 0; // Reads that never saw completion
  initial begin
    {cs_n, rd_n, wr_n, addr_strobe_n} = 4'hF;
    host_addr_bus = 16'hFFFF;
    host_data_bus_in = 8'hFF;
  end
  // Write: data set up with the strobe, select outlives it by a cycle
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(negedge sys_clk);
      {cs_n, wr_n, host_addr_bus, host_data_bus_in} = {2'h0, a, d};
      repeat (5) @(negedge sys_clk);
      wr_n = 1'b1;
      @(negedge sys_clk);
      {cs_n, host_addr_bus, host_data_bus_in} = {1'b1, ~a, ~d};
      repeat (10) @(negedge sys_clk);
    end
  endtask
  // Read: strobe stays until the wait line reports completion, and one
  // clock beyond, so the data still stands while completion is shown
  task rd(input [15:0] a, output [7:0] d);
    begin
      @(negedge sys_clk);
      {cs_n, rd_n, host_addr_bus} = {2'h0, a};
      for (i = 0; i < 12 && !(i >= 5 && wait_oe === 1'b1 && wait_out_n === 1'b1); i = i + 1)
        @(negedge sys_clk);
      if (i == 12)
        late = late + 1; // Completion never shown
      d = host_data_bus_out;
      @(negedge sys_clk);
      {cs_n, rd_n, host_addr_bus} = {2'h3, ~a};
      repeat (10) @(negedge sys_clk);
    end
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench: register, display and power save sequences.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`include "lcp_defs.vh"
module testbench;
  reg         sys_clk = 1'b0;     // 100 MHz
  reg         reset_n = 1'b0;     // Held 12 cycles
  reg         direct_mode = 1'b1; // Register access first
  reg         frame_tick = 1'b0;  // Frame pulse
  wire        cs_n, rd_n, wr_n, addr_strobe_n, host_data_bus_oe, wait_out_n, wait_oe, panel_disable_out;
  wire [15:0] host_addr_bus;
  wire [7:0]  host_data_bus_in, host_data_bus_out;
  reg  [7:0]  got;
  integer     fails = 0;
  integer     n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  lcp_host_port uut (.sys_clk, .reset_n, .cs_n, .rd_n, .wr_n, .addr_strobe_n, .host_addr_bus, .host_data_bus_in,
    .host_data_bus_out, .host_data_bus_oe, .wait_out_n, .wait_oe, .direct_mode, .frame_tick, .panel_disable_out);
  lcp_host_model host (.sys_clk, .cs_n, .rd_n, .wr_n, .addr_strobe_n, .host_addr_bus, .host_data_bus_in,
    .host_data_bus_out, .wait_out_n, .wait_oe);
  task chk(input [7:0] e, input [7:0] a);
    begin
      n_compared = n_compared + 1;
      if (a !== e) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h expected %h", $time, a, e);
      end
    end
  endtask
  task tally_and_finish;
    begin
      fails = fails + host.late;
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Run needs about 224 cycles; the limit allows 2000
  initial begin
    #20000 fails = fails + 1;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    host.rd(`LCP_REG_POWER_SAVE, got);
    chk(`LCP_POWER_SAVE_RST, got);
    host.rd(`LCP_REG_DISPLAY_ENABLE, got);
    chk(`LCP_DISPLAY_EN_RST, got);
    host.rd(16'h0010, got);
    chk(8'h00, got);
    $display("reset values done");
    host.wr(`LCP_REG_DISPLAY_ENABLE, 8'h01);
    chk(8'h01, {7'h00, panel_disable_out});
    host.rd(`LCP_REG_DISPLAY_ENABLE, got);
    chk(8'h01, got);
    host.wr(`LCP_REG_DISPLAY_ENABLE, 8'h00);
    chk(8'h00, {7'h00, panel_disable_out});
    host.wr(`LCP_REG_POWER_SAVE, 8'hA4);
    host.rd(`LCP_REG_POWER_SAVE, got);
    chk(8'hA4, got);
    $display("direct registers done");
    direct_mode = 1'b0;
    host.wr(`LCP_IND_BASE, `LCP_CMD_DISP_ON);
    chk(8'h01, {7'h00, panel_disable_out});
    host.wr(`LCP_IND_BASE, `LCP_CMD_DISP_OFF);
    chk(8'h00, {7'h00, panel_disable_out});
    host.wr(`LCP_IND_BASE, `LCP_CMD_DISP_ON);
    host.wr(`LCP_IND_BASE, `LCP_CMD_POWER_SAVE);
    chk(8'h01, {7'h00, panel_disable_out});
    repeat (2) begin
      @(negedge sys_clk) frame_tick = 1'b1;
      @(negedge sys_clk) frame_tick = 1'b0;
    end
    chk(8'h00, {7'h00, panel_disable_out});
    $display("indirect commands done");
    tally_and_finish;
  end
endmodule
